// *** rtl/pcc_pkg.sv ***
// Package with offsets, field positions, reset values, timing and types of the PLL control block.
package pcc_pkg;
    // Register offsets on the byte-wide register port.
    localparam logic [11:0] ADDR_GLOBAL_CMD = 12'h001;
    localparam logic [11:0] ADDR_REF_DIV = 12'h010;
    localparam logic [11:0] ADDR_REF_SEL = 12'h011;
    localparam logic [11:0] ADDR_IN1_CFG = 12'h012;
    localparam logic [11:0] ADDR_IN2_CFG = 12'h013;
    localparam logic [11:0] ADDR_OSC_MODE = 12'h01C;
    localparam logic [11:0] ADDR_PUMP = 12'h025;
    localparam logic [11:0] ADDR_CAP = 12'h027;
    localparam logic [11:0] ADDR_ABL = 12'h028;
    // Field positions.
    localparam int GC_WAIT_DONE_BIT = 4;
    localparam int GC_BUSY_BIT = 3;
    localparam int GC_CAL_BIT = 2;
    localparam int RS_PIN_MODE_BIT = 2;
    localparam int RS_SEL_BIT = 1;
    localparam int RS_DIV_RST_BIT = 0;
    localparam int IC_TERM_LSB = 2;
    localparam int IC_EN_BIT = 0;
    localparam int OSC_MODE_BIT = 0;
    localparam int CAP_LSB = 2;
    // Values after reset.
    localparam logic [7:0] REF_DIV_RST = 8'h01;
    localparam logic [1:0] TERM_RST = 2'h1;
    localparam logic IN_EN_RST = 1'b1;
    localparam logic [5:0] PUMP_RST = 6'h00;
    localparam logic [3:0] CAP_RST = 4'h0;
    localparam logic [1:0] ABL_RST = 2'h0;
    // Termination codes.
    localparam logic [1:0] TERM_DIFF100 = 2'h0;
    localparam logic [1:0] TERM_GND50 = 2'h1;
    localparam logic [1:0] TERM_AC50 = 2'h2;
    localparam logic [1:0] TERM_HIZ10K = 2'h3;
    // Analog scale: pump step in microamps, capacitance in half picofarads.
    localparam int PUMP_STEP_UA = 50;
    localparam int CIN_FIXED_HALF_PF = 10;
    localparam int CIN_STEP_HALF_PF = 25;
    localparam int CIN_BANK = 15;
    // Timing: power-up wait in seconds and clock rate in hertz.
    localparam int WAIT_S = 2;
    localparam int CLK_HZ = 250_000_000;
    localparam int unsigned WAIT_CYCLES = WAIT_S * CLK_HZ;
    localparam int CAL_CYCLES = 64;
    localparam int ABL_BASE_CYCLES = 1;
    // Calibration sequencer states.
    typedef enum logic [1:0] {
        PCC_CAL_IDLE = 2'b00,
        PCC_CAL_RUN = 2'b01,
        PCC_CAL_SYNC = 2'b10
    } pcc_cal_e;
    // Decoded termination controls of one reference receiver.
    typedef struct packed {
        logic diff100;
        logic gnd50;
        logic ac50;
        logic hiz10k;
        logic bias_hiz;
    } pcc_term_s;
endpackage

// *** rtl/pcc_top.sv ***
// PLL configuration, reference mux, reference divider, phase detector and calibration sequencer.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RL1 - Pump current is 50 uA times code plus one.
// RL2 - Input capacitance 5 pF plus 12.5 pF per count.
// RL3 - Decode two-bit termination select per reference input.
// RL4 - Enable bit zero disables that reference receiver.
// RL5 - One bit picks oscillator performance or power mode.
// RL6 - Rising calibrate bit starts oscillator band calibration.
// RL7 - Calibrate bit clears itself once accepted.
// RL8 - Host writes full configuration before calibrating.
// RL9 - Host calibrates after power-up, resets, frequency changes.
// RL10 - First calibration waits two seconds after power-up.
// RL11 - Host keeps reference stable before requesting calibration.
// RL12 - Calibration end synchronizes all internal dividers.
// RL13 - Mode bit picks pin or register mux select.
// RL14 - Default ignores pin, register bit steers mux.
// RL15 - Two inputs pass a 2:1 mux into divider.
// RL16 - Each divider has a self-clearing reset bit.
// RL17 - Divider reset restarts count, keeps divide value.
// RL18 - Host resets divider after changing its value.
// RL19 - Reference divider divides by its 8-bit value.
// RL20 - Reference divider reset lives in select control.
// RL21 - Phase detector drives pump from reference versus feedback.
// RL22 - Host keeps divided reference within detector limit.
// RL23 - Adjustable antibacklash pulse removes detector dead zone.
// RL24 - Register select zero picks first, one second input.
//////////////////////////////////////////////////////////////////////////////////////////////
module pcc_top #(
    parameter int unsigned WAIT_CYCLES = pcc_pkg::WAIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ref1_i,
    input wire logic ref2_i,
    input wire logic ref_sel_pin_i,
    input wire logic fb_i,
    output logic ref1_rx_en_o,
    output logic ref2_rx_en_o,
    output pcc_pkg::pcc_term_s ref1_term_o,
    output pcc_pkg::pcc_term_s ref2_term_o,
    output logic ref_div_pulse_o,
    output logic pump_up_o,
    output logic pump_dn_o,
    output logic [5:0] pump_code_o,
    output logic [11:0] pump_ua_o,
    output logic [pcc_pkg::CIN_BANK-1:0] cin_switch_o,
    output logic [8:0] cin_half_pf_o,
    output logic osc_low_power_o,
    output logic cal_active_o,
    output logic div_sync_o
);
    localparam int CIN_BANK_W = pcc_pkg::CIN_BANK;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Termination decode, shared by both receivers.
    function automatic pcc_pkg::pcc_term_s pcc_term_decode(input logic [1:0] code);
        pcc_pkg::pcc_term_s t;
        t = '0;
        // Each select code closes exactly one termination path.
        case (code)
            pcc_pkg::TERM_DIFF100: begin
                t.diff100 = 1'b1;
                t.bias_hiz = 1'b1;
            end
            pcc_pkg::TERM_GND50: t.gnd50 = 1'b1;
            pcc_pkg::TERM_AC50: t.ac50 = 1'b1;
            default: t.hiz10k = 1'b1;
        endcase
        return t;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic [7:0] ref_div_reg; // Reference divide value.
    logic ref_pin_mode_reg; // High lets the pin steer the mux.
    logic ref_sel_reg; // Register-driven input choice.
    logic ref_div_rst_reg; // Self-clearing divider restart.
    logic [1:0] term1_reg;
    logic [1:0] term2_reg;
    logic en1_reg;
    logic en2_reg;
    logic osc_mode_reg; // High selects low-power mode.
    logic [5:0] pump_reg;
    logic [3:0] cap_reg;
    logic [1:0] abl_reg; // Extra antibacklash cycles.
    logic cal_pend_reg; // Calibrate bit as software sees it.
    logic wait_done_reg;
    logic [31:0] wait_cnt_reg;
    logic [7:0] rdata_reg;

    // Write decode, one strobe per register.
    wire wr_gc = wr_i && (addr_i == pcc_pkg::ADDR_GLOBAL_CMD);
    wire wr_rd = wr_i && (addr_i == pcc_pkg::ADDR_REF_DIV);
    wire wr_rs = wr_i && (addr_i == pcc_pkg::ADDR_REF_SEL);
    wire wr_i1 = wr_i && (addr_i == pcc_pkg::ADDR_IN1_CFG);
    wire wr_i2 = wr_i && (addr_i == pcc_pkg::ADDR_IN2_CFG);
    wire wr_om = wr_i && (addr_i == pcc_pkg::ADDR_OSC_MODE);
    wire wr_pc = wr_i && (addr_i == pcc_pkg::ADDR_PUMP);
    wire wr_cp = wr_i && (addr_i == pcc_pkg::ADDR_CAP);
    wire wr_ab = wr_i && (addr_i == pcc_pkg::ADDR_ABL);

    // Only a 0 to 1 change of the stored bit counts as a new command.
    wire cal_rise = wr_gc && wdata_i[pcc_pkg::GC_CAL_BIT] && !cal_pend_reg; // [RL6]
    pcc_pkg::pcc_cal_e cal_state_reg;
    pcc_pkg::pcc_cal_e cal_state_next;
    // Accept only once the power-up wait is over and no calibration runs.
    wire cal_accept = cal_pend_reg && wait_done_reg && (cal_state_reg == pcc_pkg::PCC_CAL_IDLE); // [RL10]

    // Configuration writes; divider reset self-clears the cycle after it is set.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_div_reg <= pcc_pkg::REF_DIV_RST;
            ref_pin_mode_reg <= 1'b0; // [RL14]
            ref_sel_reg <= 1'b0;
            ref_div_rst_reg <= 1'b0;
            term1_reg <= pcc_pkg::TERM_RST;
            term2_reg <= pcc_pkg::TERM_RST;
            en1_reg <= pcc_pkg::IN_EN_RST;
            en2_reg <= pcc_pkg::IN_EN_RST;
            osc_mode_reg <= 1'b0;
            pump_reg <= pcc_pkg::PUMP_RST;
            cap_reg <= pcc_pkg::CAP_RST;
            abl_reg <= pcc_pkg::ABL_RST;
        end else begin
            if (wr_rd) begin
                ref_div_reg <= wdata_i;
            end
            if (wr_rs) begin
                ref_pin_mode_reg <= wdata_i[pcc_pkg::RS_PIN_MODE_BIT]; // [RL13]
                ref_sel_reg <= wdata_i[pcc_pkg::RS_SEL_BIT];
            end
            ref_div_rst_reg <= wr_rs && wdata_i[pcc_pkg::RS_DIV_RST_BIT]; // [RL16] [RL20]
            if (wr_i1) begin
                term1_reg <= wdata_i[pcc_pkg::IC_TERM_LSB +: 2];
                en1_reg <= wdata_i[pcc_pkg::IC_EN_BIT];
            end
            if (wr_i2) begin
                term2_reg <= wdata_i[pcc_pkg::IC_TERM_LSB +: 2];
                en2_reg <= wdata_i[pcc_pkg::IC_EN_BIT];
            end
            if (wr_om) begin
                osc_mode_reg <= wdata_i[pcc_pkg::OSC_MODE_BIT]; // [RL5]
            end
            if (wr_pc) begin
                pump_reg <= wdata_i[5:0];
            end
            if (wr_cp) begin
                cap_reg <= wdata_i[pcc_pkg::CAP_LSB +: 4];
            end
            if (wr_ab) begin
                abl_reg <= wdata_i[1:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Power-up wait timer and calibrate command.
    // The timer runs once after reset; later calibrations are never gated by it.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_cnt_reg <= 32'h0000_0000;
            wait_done_reg <= 1'b0;
        end else if (!wait_done_reg) begin
            wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
            wait_done_reg <= (wait_cnt_reg == 32'(WAIT_CYCLES - 1)); // [RL10]
        end
    end

    // A command written during the wait stays pending; acceptance clears it.
    // A write of the bit in the accept cycle is not a rise, since the bit is still pending, so the clear wins.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cal_pend_reg <= 1'b0;
        end else if (cal_rise) begin
            cal_pend_reg <= 1'b1;
        end else if (cal_accept) begin
            cal_pend_reg <= 1'b0; // [RL7]
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer: run the band search, then pulse the divider sync.
    logic [6:0] cal_cnt_reg;
    wire cal_last = (cal_cnt_reg == 7'(pcc_pkg::CAL_CYCLES - 1));

    always_comb begin
        cal_state_next = cal_state_reg;
        case (cal_state_reg)
            pcc_pkg::PCC_CAL_IDLE: begin
                if (cal_accept) begin
                    cal_state_next = pcc_pkg::PCC_CAL_RUN; // [RL6]
                end
            end
            pcc_pkg::PCC_CAL_RUN: begin
                if (cal_last) begin
                    cal_state_next = pcc_pkg::PCC_CAL_SYNC;
                end
            end
            default: cal_state_next = pcc_pkg::PCC_CAL_IDLE;
        endcase
    end

    // State and band-search duration counter.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cal_state_reg <= pcc_pkg::PCC_CAL_IDLE;
            cal_cnt_reg <= 7'h00;
        end else begin
            cal_state_reg <= cal_state_next;
            cal_cnt_reg <= (cal_state_reg == pcc_pkg::PCC_CAL_RUN) ? cal_cnt_reg + 7'h01 : 7'h00;
        end
    end

    assign cal_active_o = (cal_state_reg == pcc_pkg::PCC_CAL_RUN);
    assign div_sync_o = (cal_state_reg == pcc_pkg::PCC_CAL_SYNC); // [RL12]

    //////////////////////////////////////////////////////////////////////////////////////////
    // Reference receivers and input mux.
    wire ref1_g = ref1_i && en1_reg; // [RL4]
    wire ref2_g = ref2_i && en2_reg; // [RL4]
    wire sel_second = ref_pin_mode_reg ? ref_sel_pin_i : ref_sel_reg; // [RL13] [RL24]
    wire ref_mux = sel_second ? ref2_g : ref1_g; // [RL15]
    assign ref1_rx_en_o = en1_reg;
    assign ref2_rx_en_o = en2_reg;
    assign ref1_term_o = pcc_term_decode(term1_reg); // [RL3]
    assign ref2_term_o = pcc_term_decode(term2_reg); // [RL3]

    //////////////////////////////////////////////////////////////////////////////////////////
    // Reference divider: one pulse per ref_div_reg rising edges of the chosen input.
    logic ref_prev_reg;
    logic fb_prev_reg;
    logic [7:0] rdiv_cnt_reg;
    logic rdiv_pulse_reg;
    wire ref_edge = ref_mux && !ref_prev_reg;
    wire fb_edge = fb_i && !fb_prev_reg;
    // A value of zero is outside the legal range and leaves the divider silent.
    wire rdiv_wrap = ref_edge && (ref_div_reg != 8'h00) && (rdiv_cnt_reg >= ref_div_reg - 8'h01);
    // Restart clears the count but leaves the programmed value alone.
    wire rdiv_restart = ref_div_rst_reg || div_sync_o; // [RL17] [RL12]

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_prev_reg <= 1'b0;
            fb_prev_reg <= 1'b0;
            rdiv_cnt_reg <= 8'h00;
            rdiv_pulse_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_mux;
            fb_prev_reg <= fb_i;
            rdiv_pulse_reg <= rdiv_wrap && !rdiv_restart; // [RL19]
            if (rdiv_restart || rdiv_wrap) begin
                rdiv_cnt_reg <= 8'h00; // [RL17]
            end else if (ref_edge) begin
                rdiv_cnt_reg <= rdiv_cnt_reg + 8'h01;
            end
        end
    end
    assign ref_div_pulse_o = rdiv_pulse_reg;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Phase detector: up on divided reference, down on feedback, both clear after a delay.
    // Holding both outputs briefly is what removes the dead zone around zero phase error.
    logic up_reg;
    logic dn_reg;
    logic [2:0] abl_cnt_reg;
    wire [2:0] abl_len = 3'(pcc_pkg::ABL_BASE_CYCLES) + {1'b0, abl_reg};
    wire pfd_clr = up_reg && dn_reg && (abl_cnt_reg >= abl_len - 3'h1); // [RL23]

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            abl_cnt_reg <= 3'h0;
        end else begin
            // A new edge in the clearing cycle is kept, so no edge is lost.
            up_reg <= (up_reg && !pfd_clr) || rdiv_pulse_reg; // [RL21]
            dn_reg <= (dn_reg && !pfd_clr) || fb_edge; // [RL21]
            abl_cnt_reg <= (up_reg && dn_reg && !pfd_clr) ? abl_cnt_reg + 3'h1 : 3'h0;
        end
    end
    assign pump_up_o = up_reg;
    assign pump_dn_o = dn_reg;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Analog settings: pump current, op-amp input capacitance, oscillator mode.
    assign pump_code_o = pump_reg;
    assign pump_ua_o = 12'(pcc_pkg::PUMP_STEP_UA * (32'(pump_reg) + 1)); // [RL1]
    assign cin_half_pf_o = 9'(pcc_pkg::CIN_FIXED_HALF_PF + pcc_pkg::CIN_STEP_HALF_PF * 32'(cap_reg)); // [RL2]
    genvar gi;
    // One switched capacitor per count, filled as a thermometer code.
    generate
        for (gi = 0; gi < CIN_BANK_W; gi++) begin : g_cin
            assign cin_switch_o[gi] = (32'(cap_reg) > gi); // [RL2]
        end
    endgenerate
    assign osc_low_power_o = osc_mode_reg; // [RL5]

    //////////////////////////////////////////////////////////////////////////////////////////
    // Read port: data stand in the cycle after the strobe; unmapped reads give zero.
    wire [7:0] gc_rd = {3'h0, wait_done_reg, cal_state_reg != pcc_pkg::PCC_CAL_IDLE, cal_pend_reg, 2'h0};
    wire [7:0] rs_rd = {5'h00, ref_pin_mode_reg, ref_sel_reg, 1'b0};
    wire [7:0] rd_mux = (addr_i == pcc_pkg::ADDR_GLOBAL_CMD) ? gc_rd :
                        (addr_i == pcc_pkg::ADDR_REF_DIV) ? ref_div_reg :
                        (addr_i == pcc_pkg::ADDR_REF_SEL) ? rs_rd :
                        (addr_i == pcc_pkg::ADDR_IN1_CFG) ? {4'h0, term1_reg, 1'b0, en1_reg} :
                        (addr_i == pcc_pkg::ADDR_IN2_CFG) ? {4'h0, term2_reg, 1'b0, en2_reg} :
                        (addr_i == pcc_pkg::ADDR_OSC_MODE) ? {7'h00, osc_mode_reg} :
                        (addr_i == pcc_pkg::ADDR_PUMP) ? {2'h0, pump_reg} :
                        (addr_i == pcc_pkg::ADDR_CAP) ? {2'h0, cap_reg, 2'h0} :
                        (addr_i == pcc_pkg::ADDR_ABL) ? {6'h00, abl_reg} : 8'h00;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_i ? rd_mux : 8'h00;
        end
    end
    assign rdata_o = rdata_reg;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the sequences above.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_pump_current;
        wr_pc |=> (pump_ua_o == 12'(50 * (32'($past(wdata_i[5:0])) + 1)));
    endproperty
    a_pump_current: assert property (p_pump_current) else $error("pump current wrong"); // [RL1]

    property p_cin_value;
        wr_cp |=> (cin_half_pf_o == 9'(10 + 25 * 32'($past(wdata_i[5:2])))) && ($countones(cin_switch_o) == 32'($past(wdata_i[5:2])));
    endproperty
    a_cin_value: assert property (p_cin_value) else $error("capacitance wrong"); // [RL2]

    property p_term_default;
        $rose(wait_cnt_reg == 32'h0000_0001) && $past(wait_cnt_reg == 32'h0000_0000) && !$past(wr_i1) |-> (term1_reg == 2'h1) || $past(wr_i1, 2);
    endproperty
    a_term_default: assert property (p_term_default) else $error("termination default wrong"); // [RL3]

    property p_term_onehot;
        $onehot({ref1_term_o.diff100, ref1_term_o.gnd50, ref1_term_o.ac50, ref1_term_o.hiz10k}) && (ref1_term_o.bias_hiz == (term1_reg == 2'h0));
    endproperty
    a_term_onehot: assert property (p_term_onehot) else $error("termination decode wrong"); // [RL3]

    property p_rx_disable;
        (!en1_reg && !sel_second) || (!en2_reg && sel_second) |=> !ref_prev_reg;
    endproperty
    a_rx_disable: assert property (p_rx_disable) else $error("disabled input passed"); // [RL4]

    property p_mux_sel;
        !ref_pin_mode_reg |-> (sel_second == ref_sel_reg);
    endproperty
    a_mux_sel: assert property (p_mux_sel) else $error("mux ignored register select"); // [RL14]

    property p_wait_gate;
        !wait_done_reg |-> (cal_state_reg == pcc_pkg::PCC_CAL_IDLE);
    endproperty
    a_wait_gate: assert property (p_wait_gate) else $error("calibration before wait"); // [RL10]

    property p_self_clear;
        cal_accept && !cal_rise |=> !cal_pend_reg && cal_active_o;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("calibrate bit stuck"); // [RL7]

    sequence s_cal_run;
        $rose(cal_active_o) ##1 cal_active_o [*8];
    endsequence
    sequence s_cal_sync;
        ##[1:64] div_sync_o ##1 !div_sync_o;
    endsequence
    property p_cal_sync;
        s_cal_run |-> s_cal_sync;
    endproperty
    a_cal_sync: assert property (p_cal_sync) else $error("no sync after calibration"); // [RL12]

    property p_div_restart;
        ref_div_rst_reg |=> (rdiv_cnt_reg == 8'h00) && (ref_div_reg == $past(ref_div_reg));
    endproperty
    a_div_restart: assert property (p_div_restart) else $error("divider restart wrong"); // [RL17]

    property p_pfd_release;
        up_reg && dn_reg |-> ##[1:5] !(up_reg && dn_reg) || rdiv_pulse_reg || fb_edge;
    endproperty
    a_pfd_release: assert property (p_pfd_release) else $error("detector stuck"); // [RL23]
endmodule

// *** verif/pcc_ref_src.sv ***
// Model of the reference clock sources and feedback path facing the PLL control block.
`timescale 1ns/100ps
module pcc_ref_src #(
    parameter int H1 = 2,
    parameter int H2 = 5,
    parameter int HF = 6
) (
    input wire logic clk_i,
    output logic ref1_o,
    output logic ref2_o,
    output logic fb_o
);
    // Cycle counter shared by all three sources.
    int c = 0;
    initial begin
        ref1_o = 1'b0;
        ref2_o = 1'b0;
        fb_o = 1'b0;
    end
    // Sources run free and steady, so calibration always sees a stable reference.
    always @(posedge clk_i) begin
        c <= c + 1;
        if ((c % H1) == H1 - 1) ref1_o <= ~ref1_o;
        if ((c % H2) == H2 - 1) ref2_o <= ~ref2_o;
        if ((c % HF) == HF - 1) fb_o <= ~fb_o;
    end
endmodule

// *** verif/pcc_top_test.sv ***
// Self-checking testbench of the PLL configuration and calibration block.
`timescale 1ns/100ps
module pcc_top_test;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sel_pin = 1'b0;
    logic [7:0] rdata_o;
    logic ref1, ref2, fb, en1, en2, pulse, up, dn, lowp, cal, sync;
    pcc_pkg::pcc_term_s t1, t2;
    logic [5:0] pcode;
    logic [11:0] ua;
    logic [14:0] csw;
    logic [8:0] chalf;
    int error_cnt = 0;
    int comparisons = 0;
    always #2 clk_i = ~clk_i;
    // A short power-up wait keeps the run brief.
    pcc_top #(.WAIT_CYCLES(20)) uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref1_i(ref1),
        .ref2_i(ref2), .ref_sel_pin_i(sel_pin), .fb_i(fb), .ref1_rx_en_o(en1),
        .ref2_rx_en_o(en2), .ref1_term_o(t1), .ref2_term_o(t2), .ref_div_pulse_o(pulse),
        .pump_up_o(up), .pump_dn_o(dn), .pump_code_o(pcode), .pump_ua_o(ua),
        .cin_switch_o(csw), .cin_half_pf_o(chalf), .osc_low_power_o(lowp),
        .cal_active_o(cal), .div_sync_o(sync));
    pcc_ref_src src (.clk_i(clk_i), .ref1_o(ref1), .ref2_o(ref2), .fb_o(fb));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Write takes one strobe cycle; return once the new value has settled.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample it there.
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(16'(rdata_o), 16'(e));
    endtask
    // Count cycles until the calibration flag shows the given level, bounded.
    task automatic till_cal(input logic v, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (cal !== v && n < 500);
    endtask
    task automatic till_pulse(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (pulse !== 1'b1 && n < 1100);
    endtask
    // Count cycles with the divider pulse and with the down output high.
    task automatic cnt_hi(input int c, output int np, output int nd);
        np = 0;
        nd = 0;
        repeat (c) begin
            @(posedge clk_i);
            #1;
            np += int'(pulse === 1'b1);
            nd += int'(dn === 1'b1);
        end
    endtask
    // Third interval only: earlier ones may straddle a source switch.
    task automatic gap(input int e);
        int n;
        repeat (3) till_pulse(n);
        chk(16'(n), 16'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_cal();
        int n;
        wr(pcc_pkg::ADDR_REF_DIV, pcc_pkg::REF_DIV_RST);
        wr(pcc_pkg::ADDR_GLOBAL_CMD, 8'h04);
        till_cal(1'b1, n);
        chk(16'(n >= 14 && n <= 24), 16'h0001);
        till_cal(1'b0, n);
        chk(16'(n), 16'd64);
        chk(16'(sync), 16'h0001);
        @(posedge clk_i);
        #1;
        chk(16'(sync), 16'h0000);
        rd(pcc_pkg::ADDR_GLOBAL_CMD, 8'h10);
        wr(pcc_pkg::ADDR_GLOBAL_CMD, 8'h04);
        till_cal(1'b1, n);
        chk(16'(n), 16'h0001);
        till_cal(1'b0, n);
        // The run started one cycle before the count began.
        chk(16'(n), 16'(pcc_pkg::CAL_CYCLES - 1));
    endtask
    task automatic t_reset();
        rd(pcc_pkg::ADDR_REF_DIV, pcc_pkg::REF_DIV_RST);
        rd(pcc_pkg::ADDR_IN1_CFG, 8'h05);
        rd(pcc_pkg::ADDR_REF_SEL, 8'h00);
        rd(12'h3FF, 8'h00);
        chk(16'(t1), 16'h0008);
        chk(16'(en1), 16'h0001);
    endtask
    task automatic t_analog();
        for (int i = 0; i < 64; i += 17) begin
            wr(pcc_pkg::ADDR_PUMP, 8'(i));
            chk(16'(ua), 16'(50 * (i + 1)));
            chk(16'(pcode), 16'(i));
        end
        for (int i = 0; i < 16; i += 5) begin
            wr(pcc_pkg::ADDR_CAP, 8'(i << 2));
            chk(16'(chalf), 16'(10 + 25 * i));
            chk(16'(csw), 16'((1 << i) - 1));
        end
        for (int i = 1; i >= 0; i--) begin
            wr(pcc_pkg::ADDR_OSC_MODE, 8'(i));
            chk(16'(lowp), 16'(i));
        end
        // Longest antibacklash setting stays in force for the divider tests.
        wr(pcc_pkg::ADDR_ABL, 8'h03);
        rd(pcc_pkg::ADDR_ABL, 8'h03);
    endtask
    task automatic t_term();
        logic [4:0] tt[4] = '{5'b10001, 5'b01000, 5'b00100, 5'b00010};
        int n;
        int m;
        for (int i = 0; i < 4; i++) begin
            wr(pcc_pkg::ADDR_IN1_CFG, 8'((i << 2) | 1));
            wr(pcc_pkg::ADDR_IN2_CFG, 8'(i << 2));
            chk(16'(t1), 16'(tt[i]));
            chk(16'(t2), 16'(tt[i]));
            chk(16'({en1, en2}), 16'h0002);
        end
        // Steer the mux to the disabled second input: no divider pulse may pass.
        wr(pcc_pkg::ADDR_REF_SEL, 8'h02);
        cnt_hi(40, n, m);
        chk(16'(n), 16'h0000);
        wr(pcc_pkg::ADDR_IN2_CFG, 8'h05);
    endtask
    task automatic t_div();
        int n;
        int m;
        wr(pcc_pkg::ADDR_REF_DIV, 8'h03);
        wr(pcc_pkg::ADDR_REF_SEL, 8'h01);
        gap(12);
        wr(pcc_pkg::ADDR_REF_SEL, 8'h03);
        gap(30);
        @(posedge clk_i);
        sel_pin <= 1'b1;
        wr(pcc_pkg::ADDR_REF_SEL, 8'h05);
        gap(30);
        @(posedge clk_i);
        sel_pin <= 1'b0;
        gap(12);
        rd(pcc_pkg::ADDR_REF_SEL, 8'h04);
        rd(pcc_pkg::ADDR_REF_DIV, 8'h03);
        @(posedge clk_i);
        sel_pin <= 1'b1;
        wr(pcc_pkg::ADDR_REF_SEL, 8'h00);
        gap(12);
        wr(pcc_pkg::ADDR_REF_DIV, 8'hFF);
        wr(pcc_pkg::ADDR_REF_SEL, 8'h01);
        gap(1020);
        wr(pcc_pkg::ADDR_REF_DIV, 8'h01);
        wr(pcc_pkg::ADDR_REF_SEL, 8'h01);
        gap(4);
        // Up follows each divider pulse; down rises on feedback and is released.
        @(posedge clk_i);
        #1;
        chk(16'(up), 16'h0001);
        cnt_hi(24, n, m);
        chk(16'(n), 16'd6);
        chk(16'(m > 0 && m < 24), 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Guard against a hung handshake; the full run needs far less time.
    initial begin
        #200_000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_cal();
        t_reset();
        t_analog();
        t_term();
        t_div();
        close_out();
    end
endmodule
